// ### src/pmsc_pkg.sv
/*
  package for the power management status and control block: register
  indices, bit positions, reset values and synchroniser depth.
  assumes a plain register port with 8-bit data in the low bits.
*/
package pmsc_pkg;
  // ------------------------------------------------------------------
  // register map (word indices on the plain port)
  // ------------------------------------------------------------------
  localparam logic [1:0] PMSC_IDX_DETECT = 2'h0; // lowvolt detect ctrl
  localparam logic [1:0] PMSC_IDX_STOP = 2'h1; // stop mode ctrl
  localparam logic [1:0] PMSC_IDX_WARN = 2'h2; // lowvolt warning ctrl
  localparam logic [1:0] PMSC_IDX_INFO = 2'h3; // reset cause / id
  // ------------------------------------------------------------------
  // detect register fields
  // ------------------------------------------------------------------
  localparam int PMSC_B_LVD_FLAG = 7;
  localparam int PMSC_B_LVD_ACK = 6;
  localparam int PMSC_B_LVD_IRQ_EN = 5;
  localparam int PMSC_B_LVD_RST_EN = 4;
  localparam int PMSC_B_LVD_STOP_EN = 3;
  localparam int PMSC_B_LVD_EN = 2;
  localparam int PMSC_B_RSVD = 1;
  localparam int PMSC_B_BGBUF_EN = 0;
  // ------------------------------------------------------------------
  // stop register fields
  // ------------------------------------------------------------------
  localparam int PMSC_B_FULL_PD_FLAG = 4;
  localparam int PMSC_B_PART_PD_FLAG = 3;
  localparam int PMSC_B_PD_ACK = 2;
  localparam int PMSC_B_PD_ALLOW = 1;
  localparam int PMSC_B_PD_MODE = 0;
  // ------------------------------------------------------------------
  // warning register fields
  // ------------------------------------------------------------------
  localparam int PMSC_B_LVW_FLAG = 7;
  localparam int PMSC_B_LVW_ACK = 6;
  localparam int PMSC_B_DET_TRIP = 5;
  localparam int PMSC_B_WARN_TRIP = 4;
  // ------------------------------------------------------------------
  // info register fields (reset cause)
  // ------------------------------------------------------------------
  localparam int PMSC_B_CAUSE_POR = 0;
  localparam int PMSC_B_CAUSE_LVD = 1;
  localparam int PMSC_B_CAUSE_OTHER = 2;
  localparam int PMSC_INFO_ID_LSB = 4;
  // ------------------------------------------------------------------
  // reset values and misc
  // ------------------------------------------------------------------
  localparam logic [7:0] PMSC_ZERO8 = 8'h00;
  localparam logic [3:0] PMSC_ID_DEFAULT = 4'h5; // arbitrary value
  localparam int PMSC_SYNC_STAGES = 2;
endpackage

// ### src/pmsc_top.sv
/*
  power management status and control registers: low-voltage detect and
  warning flags, write-once enables, stop-mode selection and recovery
  flags. assumes comparator outputs and stop-sequencer strobes come from
  outside; comparator levels are treated as asynchronous and resynced.
*/
// Chosen here: the plain strobed port and the placing of the registers.
module pmsc_top
  import pmsc_pkg::*;
#(
  parameter logic [3:0] ID_CODE = PMSC_ID_DEFAULT // arbitrary value
) (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst, // any reset, synchronous, active high
  input wire logic por_rst, // power-on reset cause, with sys_rst
  input wire logic lvd_rst, // low-voltage reset cause, with sys_rst
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog comparators
  input wire logic lvd_cmp, // supply below detect trip
  input wire logic lvw_cmp, // supply below warning trip
  // stop-mode sequencer
  input wire logic in_stop, // device in stop mode
  input wire logic full_pd_wake, // pulse: recovered from full pd
  input wire logic part_pd_wake, // pulse: recovered from partial pd
  // control outputs
  output logic lvd_irq,
  output logic lvd_reset_req,
  output logic bandgap_buffer_en,
  output logic detect_trip_select,
  output logic warning_trip_select,
  output logic full_powerdown_stop,
  output logic partial_powerdown_stop,
  output logic lvd_active
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [PMSC_SYNC_STAGES-1:0] lvd_sync_q; // detect comparator sync
  logic [PMSC_SYNC_STAGES-1:0] lvw_sync_q; // warning comparator sync
  logic low_volt_detect_flag_q;
  logic low_volt_detect_irq_en_q;
  logic low_volt_detect_reset_en_q;
  logic low_volt_detect_stop_en_q;
  logic low_volt_detect_en_q;
  logic bandgap_q;
  logic detect_locked_q; // write-once bits already written
  logic full_powerdown_flag_q;
  logic partial_powerdown_flag_q;
  logic powerdown_allow_q;
  logic powerdown_mode_select_q;
  logic stop_locked_q; // allow bit already written
  logic low_volt_warning_flag_q;
  logic detect_trip_q;
  logic warning_trip_q;
  logic [2:0] cause_q; // last reset cause
  logic lvd_now; // synced detect level
  logic lvw_now; // synced warning level
  logic lvd_live; // detection currently operating
  logic wr_det, wr_stop, wr_warn;

  // ------------------------------------------------------------------
  // comparator synchronisers
  // ------------------------------------------------------------------
  // last stage only is read; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvd_sync_q <= '0;
      lvw_sync_q <= '0;
    end else begin
      lvd_sync_q <= {lvd_sync_q[PMSC_SYNC_STAGES-2:0], lvd_cmp};
      lvw_sync_q <= {lvw_sync_q[PMSC_SYNC_STAGES-2:0], lvw_cmp};
    end
  end
  assign lvd_now = lvd_sync_q[PMSC_SYNC_STAGES-1];
  assign lvw_now = lvw_sync_q[PMSC_SYNC_STAGES-1];

  // detection runs when enabled, and in stop only if stop enable set
  assign lvd_live = low_volt_detect_en_q &&
                    (!in_stop || low_volt_detect_stop_en_q);

  assign wr_det = reg_wr && (reg_addr == PMSC_IDX_DETECT);
  assign wr_stop = reg_wr && (reg_addr == PMSC_IDX_STOP);
  assign wr_warn = reg_wr && (reg_addr == PMSC_IDX_WARN);

  // ------------------------------------------------------------------
  // detect control register
  // ------------------------------------------------------------------
  // enable and reset enable lock after the first write; the reserved
  // bit is not stored, software is expected to write it as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_volt_detect_en_q <= 1'b0;
      low_volt_detect_reset_en_q <= 1'b0;
      low_volt_detect_irq_en_q <= 1'b0;
      low_volt_detect_stop_en_q <= 1'b0;
      bandgap_q <= 1'b0;
      detect_locked_q <= 1'b0;
    end else if (wr_det) begin
      if (!detect_locked_q) begin
        low_volt_detect_en_q <= reg_wdata[PMSC_B_LVD_EN];
        low_volt_detect_reset_en_q <= reg_wdata[PMSC_B_LVD_RST_EN];
        detect_locked_q <= 1'b1;
      end
      low_volt_detect_irq_en_q <= reg_wdata[PMSC_B_LVD_IRQ_EN];
      low_volt_detect_stop_en_q <= reg_wdata[PMSC_B_LVD_STOP_EN];
      bandgap_q <= reg_wdata[PMSC_B_BGBUF_EN];
    end
  end

  // detect flag: event wins over an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_volt_detect_flag_q <= 1'b0;
    end else if (lvd_live && lvd_now) begin
      low_volt_detect_flag_q <= 1'b1;
    end else if (wr_det && reg_wdata[PMSC_B_LVD_ACK]) begin
      low_volt_detect_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // stop mode register
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerdown_allow_q <= 1'b0;
      powerdown_mode_select_q <= 1'b0;
      stop_locked_q <= 1'b0;
    end else if (wr_stop) begin
      if (!stop_locked_q) begin
        powerdown_allow_q <= reg_wdata[PMSC_B_PD_ALLOW];
        stop_locked_q <= 1'b1;
      end
      powerdown_mode_select_q <= reg_wdata[PMSC_B_PD_MODE];
    end
  end

  // recovery flags survive sys_rst unless por_rst comes with it;
  // wake pulses win over the acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst && por_rst) begin
      full_powerdown_flag_q <= 1'b0;
      partial_powerdown_flag_q <= 1'b0;
    end else begin
      if (full_pd_wake) begin
        full_powerdown_flag_q <= 1'b1;
      end else if (wr_stop && reg_wdata[PMSC_B_PD_ACK]) begin
        full_powerdown_flag_q <= 1'b0;
      end
      if (part_pd_wake) begin
        partial_powerdown_flag_q <= 1'b1;
      end else if (wr_stop && reg_wdata[PMSC_B_PD_ACK]) begin
        partial_powerdown_flag_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // warning register
  // ------------------------------------------------------------------
  // trip selects keep their value except over power-on reset
  always_ff @(posedge clk) begin
    if (sys_rst && por_rst) begin
      detect_trip_q <= 1'b0;
      warning_trip_q <= 1'b0;
    end else if (!sys_rst && wr_warn) begin
      detect_trip_q <= reg_wdata[PMSC_B_DET_TRIP];
      warning_trip_q <= reg_wdata[PMSC_B_WARN_TRIP];
    end
  end

  // warning flag: set while low, even straight after reset; ack only
  // clears once the warning has gone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_volt_warning_flag_q <= 1'b0;
    end else if (lvw_now) begin
      low_volt_warning_flag_q <= 1'b1;
    end else if (wr_warn && reg_wdata[PMSC_B_LVW_ACK]) begin
      low_volt_warning_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // reset cause capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cause_q[PMSC_B_CAUSE_POR] <= por_rst;
      cause_q[PMSC_B_CAUSE_LVD] <= lvd_rst && !por_rst;
      cause_q[PMSC_B_CAUSE_OTHER] <= !lvd_rst && !por_rst;
    end
  end

  // ------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= PMSC_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= PMSC_ZERO8; // ack bits and reserved read zero
      if (reg_addr == PMSC_IDX_DETECT) begin
        reg_rdata[PMSC_B_LVD_FLAG] <= low_volt_detect_flag_q;
        reg_rdata[PMSC_B_LVD_IRQ_EN] <= low_volt_detect_irq_en_q;
        reg_rdata[PMSC_B_LVD_RST_EN] <= low_volt_detect_reset_en_q;
        reg_rdata[PMSC_B_LVD_STOP_EN] <= low_volt_detect_stop_en_q;
        reg_rdata[PMSC_B_LVD_EN] <= low_volt_detect_en_q;
        reg_rdata[PMSC_B_BGBUF_EN] <= bandgap_q;
      end else if (reg_addr == PMSC_IDX_STOP) begin
        reg_rdata[PMSC_B_FULL_PD_FLAG] <= full_powerdown_flag_q;
        reg_rdata[PMSC_B_PART_PD_FLAG] <= partial_powerdown_flag_q;
        reg_rdata[PMSC_B_PD_ALLOW] <= powerdown_allow_q;
        reg_rdata[PMSC_B_PD_MODE] <= powerdown_mode_select_q;
      end else if (reg_addr == PMSC_IDX_WARN) begin
        reg_rdata[PMSC_B_LVW_FLAG] <= low_volt_warning_flag_q;
        reg_rdata[PMSC_B_DET_TRIP] <= detect_trip_q;
        reg_rdata[PMSC_B_WARN_TRIP] <= warning_trip_q;
      end else begin
        reg_rdata <= {ID_CODE, 1'b0, cause_q};
      end
    end else begin
      reg_rdata <= PMSC_ZERO8;
    end
  end

  // ------------------------------------------------------------------
  // registered control outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvd_irq <= 1'b0;
      lvd_reset_req <= 1'b0;
      bandgap_buffer_en <= 1'b0;
      detect_trip_select <= 1'b0;
      warning_trip_select <= 1'b0;
      full_powerdown_stop <= 1'b0;
      partial_powerdown_stop <= 1'b0;
      lvd_active <= 1'b0;
    end else begin
      lvd_irq <= low_volt_detect_irq_en_q && low_volt_detect_flag_q;
      lvd_reset_req <= low_volt_detect_reset_en_q && low_volt_detect_en_q
                       && low_volt_detect_flag_q;
      bandgap_buffer_en <= bandgap_q;
      detect_trip_select <= detect_trip_q;
      warning_trip_select <= warning_trip_q;
      full_powerdown_stop <= powerdown_allow_q
                             && !powerdown_mode_select_q;
      partial_powerdown_stop <= powerdown_allow_q
                                && powerdown_mode_select_q;
      lvd_active <= lvd_live;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    (low_volt_detect_irq_en_q && low_volt_detect_flag_q) |=> lvd_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_rst;
    @(posedge clk) disable iff (sys_rst)
    lvd_reset_req |-> $past(low_volt_detect_en_q);
  endproperty
  a_rst: assert property (p_rst) else $error("reset without enable");

  property p_lock;
    @(posedge clk) disable iff (sys_rst)
    detect_locked_q |=> $stable(low_volt_detect_en_q);
  endproperty
  a_lock: assert property (p_lock) else $error("write-once broken");

  property p_lvd_set;
    @(posedge clk) disable iff (sys_rst)
    (lvd_live && lvd_now) |=> low_volt_detect_flag_q;
  endproperty
  a_lvd_set: assert property (p_lvd_set) else $error("detect not set");

  property p_warn_hold;
    @(posedge clk) disable iff (sys_rst)
    lvw_now |=> low_volt_warning_flag_q;
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("warn lost");

  property p_pd_ack;
    @(posedge clk) disable iff (sys_rst)
    (wr_stop && reg_wdata[PMSC_B_PD_ACK] && !part_pd_wake && !full_pd_wake)
      |=> !partial_powerdown_flag_q && !full_powerdown_flag_q;
  endproperty
  a_pd_ack: assert property (p_pd_ack) else $error("pd ack failed");

  property p_stop_mode;
    @(posedge clk) disable iff (sys_rst)
    partial_powerdown_stop |-> !full_powerdown_stop;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("both modes");

  property p_rd_zero;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == PMSC_IDX_DETECT) |=> !reg_rdata[PMSC_B_LVD_ACK];
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("ack read one");

  // no stop mode may be offered unless the allow bit was set
  property p_allow;
    @(posedge clk) disable iff (sys_rst)
    (full_powerdown_stop || partial_powerdown_stop)
      |-> $past(powerdown_allow_q);
  endproperty
  a_allow: assert property (p_allow) else $error("no allow");

  // ack with the warning gone must clear the flag next cycle
  property p_lvw_ack;
    @(posedge clk) disable iff (sys_rst)
    (wr_warn && reg_wdata[PMSC_B_LVW_ACK] && !lvw_now)
      |=> !low_volt_warning_flag_q;
  endproperty
  a_lvw_ack: assert property (p_lvw_ack) else $error("ack kept");

  // with detection off the comparator never reaches the flag
  property p_gate;
    @(posedge clk) disable iff (sys_rst)
    !low_volt_detect_en_q |=> !low_volt_detect_flag_q;
  endproperty
  a_gate: assert property (p_gate) else $error("flag while off");

endmodule

// ### test/test_pmsc_top.sv
/*
  self-checking bench for the power management status and control block.
  assumes a single 250 MHz clock, the plain register port and comparator
  levels driven directly by the bench; no partner model is needed.
*/
module test_pmsc_top
  import pmsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clk = 1'b0; // 4 ns period
  logic sys_rst = 1'b1; // held at start
  logic por_rst = 1'b1;
  logic lvd_rst = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic lvd_cmp = 1'b0;
  logic lvw_cmp = 1'b0;
  logic in_stop = 1'b0;
  logic full_pd_wake = 1'b0;
  logic part_pd_wake = 1'b0;
  logic lvd_irq, lvd_reset_req, bandgap_buffer_en, lvd_active;
  logic detect_trip_select, warning_trip_select;
  logic full_powerdown_stop, partial_powerdown_stop;
  int fail_count = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  // ------------------------------------------------------------------
  // device under test
  // ------------------------------------------------------------------
  pmsc_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .lvd_rst(lvd_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lvd_cmp(lvd_cmp),
    .lvw_cmp(lvw_cmp), .in_stop(in_stop), .full_pd_wake(full_pd_wake),
    .part_pd_wake(part_pd_wake), .lvd_irq(lvd_irq),
    .lvd_reset_req(lvd_reset_req), .bandgap_buffer_en(bandgap_buffer_en),
    .detect_trip_select(detect_trip_select),
    .warning_trip_select(warning_trip_select),
    .full_powerdown_stop(full_powerdown_stop),
    .partial_powerdown_stop(partial_powerdown_stop),
    .lvd_active(lvd_active)
  );
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  // one compare for every kind of result, outputs padded to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // single-cycle write strobe, released after the taking edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] m,
                    output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // sampled mid-cycle, then back on a rising edge for the next driver
    @(negedge clk);
    d = reg_rdata & m;
    @(posedge clk);
  endtask
  // any reset; cause inputs travel with it
  task automatic do_reset(input logic p, input logic l);
    @(posedge clk);
    sys_rst <= 1'b1;
    por_rst <= p;
    lvd_rst <= l;
    idle(10);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    lvd_rst <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_write_once;
    logic [7:0] d;
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h00, "detect reset");
    rd(PMSC_IDX_INFO, 8'hf1, d); chk(d, 8'h51, "info after por");
    wr(PMSC_IDX_DETECT, 8'h24);
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h24, "first write");
    // second write: enables frozen, irq enable still free
    wr(PMSC_IDX_DETECT, 8'h10);
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h04, "later write");
    wr(PMSC_IDX_DETECT, 8'h25);
    idle(2);
    chk({7'h0, bandgap_buffer_en}, 8'h01, "bandgap");
    chk({7'h0, lvd_active}, 8'h01, "active");
    in_stop <= 1'b1;
    idle(3);
    chk({7'h0, lvd_active}, 8'h00, "stop disables");
    // stop enable set: detection keeps running while stopped
    wr(PMSC_IDX_DETECT, 8'h2d);
    idle(2);
    chk({7'h0, lvd_active}, 8'h01, "stop keeps");
    in_stop <= 1'b0;
    wr(PMSC_IDX_DETECT, 8'h25);
  endtask
  task automatic t_detect_flag;
    logic [7:0] d;
    lvd_cmp <= 1'b1;
    idle(6);
    chk({7'h0, lvd_irq}, 8'h01, "irq on flag");
    chk({7'h0, lvd_reset_req}, 8'h00, "no reset");
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'ha5, "flag set");
    lvd_cmp <= 1'b0;
    idle(4);
    wr(PMSC_IDX_DETECT, 8'h65);
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h25, "ack clears");
    idle(1);
    chk({7'h0, lvd_irq}, 8'h00, "irq off");
    // polled mode: flag without a request
    wr(PMSC_IDX_DETECT, 8'h05);
    lvd_cmp <= 1'b1;
    idle(6);
    chk({7'h0, lvd_irq}, 8'h00, "irq masked");
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h85, "polled flag");
    lvd_cmp <= 1'b0;
  endtask
  task automatic t_stop_modes;
    logic [7:0] d;
    wr(PMSC_IDX_STOP, 8'h03);
    idle(2);
    chk({7'h0, partial_powerdown_stop}, 8'h01, "partial sel");
    chk({7'h0, full_powerdown_stop}, 8'h00, "full off");
    // allow is write-once, mode is free
    wr(PMSC_IDX_STOP, 8'h00);
    idle(2);
    chk({7'h0, full_powerdown_stop}, 8'h01, "full sel");
    @(posedge clk) part_pd_wake <= 1'b1;
    @(posedge clk) part_pd_wake <= 1'b0;
    rd(PMSC_IDX_STOP, 8'hff, d); chk(d, 8'h0a, "part flag");
    @(posedge clk) full_pd_wake <= 1'b1;
    @(posedge clk) full_pd_wake <= 1'b0;
    rd(PMSC_IDX_STOP, 8'hff, d); chk(d, 8'h1a, "full flag");
    wr(PMSC_IDX_STOP, 8'h04);
    rd(PMSC_IDX_STOP, 8'hff, d); chk(d, 8'h02, "pd ack");
  endtask
  task automatic t_warning;
    logic [7:0] d;
    lvw_cmp <= 1'b1;
    idle(5);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h80, "warn set");
    // ack refused while the warning is still present
    wr(PMSC_IDX_WARN, 8'h40);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h80, "ack held");
    lvw_cmp <= 1'b0;
    idle(5);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h80, "sticky");
    wr(PMSC_IDX_WARN, 8'h70);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h30, "ack + trips");
    idle(1);
    chk({7'h0, detect_trip_select}, 8'h01, "det trip");
    chk({7'h0, warning_trip_select}, 8'h01, "warn trip");
  endtask
  task automatic t_reset_kinds;
    logic [7:0] d;
    do_reset(1'b0, 1'b1);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h30, "trips kept");
    rd(PMSC_IDX_INFO, 8'h03, d); chk(d, 8'h02, "lvd cause");
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h00, "detect cleared");
    // write-once accepted again after any reset
    wr(PMSC_IDX_DETECT, 8'h14);
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h14, "rewrite");
    lvd_cmp <= 1'b1;
    idle(6);
    chk({7'h0, lvd_reset_req}, 8'h01, "reset req");
    lvd_cmp <= 1'b0;
    do_reset(1'b1, 1'b0);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h00, "por clears");
    idle(1);
    chk({7'h0, detect_trip_select}, 8'h00, "trip por");
    // enable cleared by reset: comparator must not reach the flag
    lvd_cmp <= 1'b1;
    lvw_cmp <= 1'b1;
    idle(6);
    chk({7'h0, lvd_active}, 8'h00, "inactive");
    rd(PMSC_IDX_DETECT, 8'hff, d); chk(d, 8'h00, "gated off");
    // supply still low across a reset: warning comes back by itself
    do_reset(1'b0, 1'b0);
    idle(4);
    rd(PMSC_IDX_WARN, 8'hff, d); chk(d, 8'h80, "low at reset");
    rd(PMSC_IDX_INFO, 8'h07, d); chk(d, 8'h04, "other cause");
    lvd_cmp <= 1'b0;
    lvw_cmp <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // closing report, the one place the run ends
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    idle(10);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    t_write_once();
    t_detect_flag();
    t_stop_modes();
    t_warning();
    t_reset_kinds();
    end_of_test();
  end
endmodule
